// [hw/ivl_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: A 32-bit APB bus with one aligned word per register.
// Notes: Definitions only; included by bare name.
`ifndef IVL_PARAMS_SVH
`define IVL_PARAMS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define IVL_OFF_CTRL 8'h00
`define IVL_OFF_TBCNT 8'h04
`define IVL_OFF_TXBUF 8'h08
`define IVL_OFF_RXBUF 8'h0C
`define IVL_OFF_IE 8'h10
`define IVL_OFF_IFG 8'h14
`define IVL_OFF_IV 8'h18
`define IVL_OFF_STAT 8'h1C

// ****************************************************************
// Control word fields.
// ****************************************************************
`define IVL_CTRL_SRST 0
`define IVL_CTRL_MST 1
`define IVL_CTRL_STT 2
`define IVL_CTRL_ETX 3
`define IVL_CTRL_ASTP_LO 4
`define IVL_CTRL_TO_LO 6
`define IVL_CTRL_RESET 8'h01

// ****************************************************************
// Flag positions, in falling priority; the vector is 2 * (pos + 1).
// ****************************************************************
`define IVL_F_AL 0
`define IVL_F_NACK 1
`define IVL_F_STT 2
`define IVL_F_STP 3
`define IVL_F_RX3 4
`define IVL_F_TX0 11
`define IVL_F_BCNT 12
`define IVL_F_CLTO 13
`define IVL_F_BIT9 14
`define IVL_NFLAG 15
`define IVL_IFG_RESET 15'h0800
`define IVL_TX_MASK 15'h0AA0
`define IVL_RX_MASK 15'h0550

// ****************************************************************
// Clock rate and clock-low timeout times.
// ****************************************************************
`define IVL_CLK_MHZ 40
`define IVL_TO1_US 25000
`define IVL_TO2_US 30000
`define IVL_TO3_US 35000

`endif

// [hw/ivl_pkg.sv]
// Purpose: Types shared by the interrupt vector logic.
// Assumes: Engine events arrive on the pclk domain.
// Notes: Constants live in ivl_params.svh.
package ivl_pkg;

    // Flag and enable vector, one bit per interrupt source.
    typedef logic [14:0] ivl_flags_t;

    // Events from the bit engine, all on pclk.
    typedef struct packed {
        logic addr_match;
        logic [1:0] match_idx;
        logic rx_load;
        logic tx_accept;
        logic arb_lost;
        logic nack;
        logic addr_phase;
        logic busy;
    } ivl_ev_s;

    // Control word as seen by the engine.
    typedef struct packed {
        logic [1:0] timeout_select;
        logic [1:0] auto_stop_select;
        logic early_tx_select;
        logic start_generate_bit;
        logic master_select;
        logic soft_reset_bit;
    } ivl_ctrl_s;

endpackage : ivl_pkg

// [hw/ivl_top.sv]
// Purpose: Flags, enables, vector and DMA requests of a two-wire interface.
// Assumes: APB master; engine events on pclk; bus pins asynchronous.
// Notes: Every APB access takes one wait state; pready comes from a flop.
`include "ivl_params.svh"

module ivl_top #(
    parameter int TO1_CYC = `IVL_TO1_US * `IVL_CLK_MHZ,
    parameter int TO2_CYC = `IVL_TO2_US * `IVL_CLK_MHZ,
    parameter int TO3_CYC = `IVL_TO3_US * `IVL_CLK_MHZ,
    parameter int CNT_W = 21
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire ivl_pkg::ivl_ev_s ev,
    input wire logic [7:0] rx_data,
    input wire logic [7:0] byte_count,
    input wire logic global_irq_enable,
    output logic irq,
    output logic [3:0] dma_tx_req,
    output logic [3:0] dma_rx_req,
    output logic clk_request,
    output ivl_pkg::ivl_ctrl_s ctrl,
    output logic [7:0] tx_data,
    output logic tx_load
);

    // ************************************************************
    // Elaboration checks.
    // ************************************************************
    if (TO1_CYC < 2 || TO2_CYC < 2 || TO3_CYC < 2 ||
        TO3_CYC >= (2 ** CNT_W) || TO2_CYC >= (2 ** CNT_W) ||
        TO1_CYC >= (2 ** CNT_W)) begin : g_chk
        $error("Timeout counts do not fit the counter.");
    end

    // ************************************************************
    // Declarations.
    // ************************************************************
    logic scl_meta_q, scl_q, scl_prev_q;
    logic sda_meta_q, sda_q, sda_prev_q;
    logic start_det, stop_det, scl_rise;
    logic [3:0] bit_cnt_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] low_lim;
    logic to_done_q;
    logic bus_busy_q;
    logic [1:0] cur_idx_q;
    logic [7:0] bc_prev_q;
    logic [7:0] tbcnt_q;
    logic [7:0] tx_cnt_q;
    logic [7:0] rxbuf_q;
    ivl_pkg::ivl_flags_t ifg_q, ifg_d, ie_q, flg_set, flg_clr;
    ivl_pkg::ivl_ctrl_s ctrl_q;
    logic [4:0] iv_val;
    logic acc, done, wr_done, rd_done;
    logic [31:0] rd_val;
    logic rd_err;
    logic wr_stt, wr_tx, rd_rx, wr_iv, rd_iv, wr_ifg;
    logic al_cleared, auto_mode, tx_gate;
    logic [3:0] rd_pos;

    // ************************************************************
    // Pin synchronisers and bus condition detection.
    // ************************************************************

    // Two flops before any logic, then one more to find edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_meta_q <= 1'b1;
            scl_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= scl_in;
            scl_q <= scl_meta_q;
            scl_prev_q <= scl_q;
            sda_meta_q <= sda_in;
            sda_q <= sda_meta_q;
            sda_prev_q <= sda_q;
        end
    end

    // Data moving while the clock is high marks START or STOP.
    assign start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign stop_det = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
    assign scl_rise = scl_q & ~scl_prev_q;

    // Bit position within a byte, restarted by every START.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= 4'h0;
        end else if (start_det) begin
            bit_cnt_q <= 4'h0;
        end else if (scl_rise) begin
            bit_cnt_q <= (bit_cnt_q == 4'h9) ? 4'h1 : bit_cnt_q + 4'h1;
        end
    end

    // Bus busy from START to STOP keeps the clock requested.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_busy_q <= 1'b0;
            clk_request <= 1'b0;
        end else begin
            if (start_det) begin
                bus_busy_q <= 1'b1;
            end else if (stop_det) begin
                bus_busy_q <= 1'b0;
            end
            clk_request <= bus_busy_q | ev.busy | start_det;
        end
    end

    // Selected clock-low limit in pclk cycles.
    always_comb begin
        case (ctrl_q.timeout_select)
            2'b01: low_lim = CNT_W'(TO1_CYC);
            2'b10: low_lim = CNT_W'(TO2_CYC);
            default: low_lim = CNT_W'(TO3_CYC);
        endcase
    end

    // Clock-low counter; fires once per low period while transferring.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_q <= '0;
            to_done_q <= 1'b0;
        end else if (scl_q || !ev.busy || ctrl_q.timeout_select == 2'b00) begin
            low_cnt_q <= '0;
            to_done_q <= 1'b0;
        end else if (!to_done_q) begin
            low_cnt_q <= low_cnt_q + CNT_W'(1);
            if (low_cnt_q == low_lim - CNT_W'(1)) begin
                to_done_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // APB slave: setup, one wait cycle, then completion.
    // ************************************************************
    assign acc = psel & penable;
    assign done = acc & pready;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;
    assign wr_stt = wr_done && paddr == `IVL_OFF_CTRL && pwdata[`IVL_CTRL_STT];
    assign wr_tx = wr_done && paddr == `IVL_OFF_TXBUF;
    assign rd_rx = rd_done && paddr == `IVL_OFF_RXBUF;
    assign wr_iv = wr_done && paddr == `IVL_OFF_IV;
    assign rd_iv = rd_done && paddr == `IVL_OFF_IV;
    assign wr_ifg = wr_done && paddr == `IVL_OFF_IFG;

    // Read mux; unmapped addresses answer with an error.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            `IVL_OFF_CTRL: rd_val = {24'h000000, ctrl_q};
            `IVL_OFF_TBCNT: rd_val = {24'h000000, tbcnt_q};
            `IVL_OFF_TXBUF: rd_val = {24'h000000, tx_data};
            `IVL_OFF_RXBUF: rd_val = {24'h000000, rxbuf_q};
            `IVL_OFF_IE: rd_val = {17'h00000, ie_q};
            `IVL_OFF_IFG: rd_val = {17'h00000, ifg_q};
            `IVL_OFF_IV: rd_val = {26'h0000000, iv_val, 1'b0};
            `IVL_OFF_STAT: rd_val = {14'h0000, bus_busy_q, clk_request,
                                     8'h00, byte_count};
            default: rd_err = 1'b1;
        endcase
    end

    // Answer one cycle into the access phase, held for that cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (acc && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= rd_err;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control, threshold and transmit buffer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `IVL_CTRL_RESET;
            tbcnt_q <= 8'h00;
            tx_data <= 8'h00;
            tx_load <= 1'b0;
        end else begin
            tx_load <= wr_tx;
            ctrl_q.start_generate_bit <= 1'b0;
            if (wr_done && paddr == `IVL_OFF_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end
            if (ev.arb_lost) begin
                ctrl_q.master_select <= 1'b0;
            end
            if (wr_done && paddr == `IVL_OFF_TBCNT) begin
                tbcnt_q <= pwdata[7:0];
            end
            if (wr_tx) begin
                tx_data <= pwdata[7:0];
            end
        end
    end

    // Enables; transmit and receive enables cleared by soft reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_q <= 15'h0000;
        end else if (ctrl_q.soft_reset_bit) begin
            ie_q <= ie_q & ~(`IVL_TX_MASK | `IVL_RX_MASK);
        end else if (wr_done && paddr == `IVL_OFF_IE) begin
            ie_q <= pwdata[14:0];
        end
    end

    // ************************************************************
    // Flag set and clear terms.
    // ************************************************************

    // Matched address index, data buffer and byte-count history.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_idx_q <= 2'b00;
            rxbuf_q <= 8'h00;
            bc_prev_q <= 8'h00;
            tx_cnt_q <= 8'h00;
        end else begin
            bc_prev_q <= byte_count;
            if (ev.addr_match) begin
                cur_idx_q <= ev.match_idx;
            end
            if (ev.rx_load) begin
                rxbuf_q <= rx_data;
            end
            if (wr_stt) begin
                tx_cnt_q <= 8'h01;
            end else if (ev.tx_accept && auto_mode && tx_gate) begin
                tx_cnt_q <= tx_cnt_q + 8'h01;
            end
        end
    end

    // Master with auto-stop gets exactly threshold transmit flags.
    assign auto_mode = ctrl_q.master_select &&
                       ctrl_q.auto_stop_select == 2'b10;
    assign tx_gate = !auto_mode || tx_cnt_q < tbcnt_q;

    // Hardware events and START writes that raise flags.
    always_comb begin
        flg_set = '0;
        if (ev.arb_lost) begin
            flg_set[`IVL_F_AL] = 1'b1;
        end
        if (ev.nack && ctrl_q.master_select) begin
            flg_set[`IVL_F_NACK] = 1'b1;
        end
        if (ev.addr_match && !ctrl_q.master_select) begin
            flg_set[`IVL_F_STT] = 1'b1;
            if (!ctrl_q.early_tx_select) begin
                flg_set[4'(`IVL_F_TX0 - 2 * ev.match_idx)] = 1'b1;
            end
        end
        if (start_det && !ctrl_q.master_select &&
            ctrl_q.early_tx_select) begin
            flg_set[`IVL_F_TX0] = 1'b1;
        end
        if (stop_det) begin
            flg_set[`IVL_F_STP] = 1'b1;
        end
        if (ev.rx_load) begin
            if (ctrl_q.master_select) begin
                flg_set[`IVL_F_TX0 - 1] = 1'b1;
            end else begin
                flg_set[4'(`IVL_F_TX0 - 1 - 2 * cur_idx_q)] = 1'b1;
            end
        end
        if (ev.tx_accept && tx_gate) begin
            if (ctrl_q.master_select) begin
                flg_set[`IVL_F_TX0] = 1'b1;
            end else begin
                flg_set[4'(`IVL_F_TX0 - 2 * cur_idx_q)] = 1'b1;
            end
        end
        if (wr_stt) begin
            flg_set[`IVL_F_TX0] = 1'b1;
        end
        if (byte_count != bc_prev_q && byte_count == tbcnt_q &&
            tbcnt_q != 8'h00 && ctrl_q.auto_stop_select != 2'b00 &&
            ctrl_q.auto_stop_select != 2'b11) begin
            flg_set[`IVL_F_BCNT] = 1'b1;
        end
        if (scl_q == 1'b0 && !to_done_q && ev.busy &&
            ctrl_q.timeout_select != 2'b00 &&
            low_cnt_q == low_lim - CNT_W'(1)) begin
            flg_set[`IVL_F_CLTO] = 1'b1;
        end
        if (scl_rise && bit_cnt_q == 4'h8 && !ev.addr_phase) begin
            flg_set[`IVL_F_BIT9] = 1'b1;
        end
    end

    // Position of the flag that a vector read reported.
    assign rd_pos = 4'(prdata[4:1] - 4'h1);

    // Software actions that clear flags.
    always_comb begin
        flg_clr = '0;
        if (rd_iv && prdata[4:1] != 4'h0) begin
            flg_clr[rd_pos] = 1'b1;
        end
        if (wr_iv) begin
            flg_clr = '1;
        end
        if (wr_tx) begin
            flg_clr = flg_clr | `IVL_TX_MASK;
        end
        if (rd_rx) begin
            flg_clr = flg_clr | `IVL_RX_MASK;
        end
    end

    // Arbitration flag dropped by any software path clears transmit flags.
    assign al_cleared = ifg_q[`IVL_F_AL] &&
                        (flg_clr[`IVL_F_AL] ||
                         (wr_ifg && !pwdata[`IVL_F_AL]));

    // Next flags: clear first, then hardware sets, then soft reset clears receive flags.
    always_comb begin
        if (wr_ifg) begin
            ifg_d = pwdata[14:0] & ~flg_clr;
        end else begin
            ifg_d = ifg_q & ~flg_clr;
        end
        if (al_cleared) begin
            ifg_d = ifg_d & ~`IVL_TX_MASK;
        end
        ifg_d = ifg_d | flg_set;
        if (ctrl_q.soft_reset_bit) begin
            ifg_d = ifg_d & ~`IVL_RX_MASK;
        end
    end

    // Flag register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ifg_q <= `IVL_IFG_RESET;
        end else begin
            ifg_q <= ifg_d;
        end
    end

    // ************************************************************
    // Vector, request and DMA outputs.
    // ************************************************************

    // Lowest position among enabled pending flags wins.
    always_comb begin
        iv_val = 5'h00;
        for (int i = `IVL_NFLAG - 1; i >= 0; i--) begin
            if (ifg_q[i] && ie_q[i]) begin
                iv_val = 5'(i + 1);
            end
        end
    end

    // Registered request, DMA triggers and control view.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            dma_tx_req <= 4'h0;
            dma_rx_req <= 4'h0;
            ctrl <= `IVL_CTRL_RESET;
        end else begin
            irq <= global_irq_enable && |(ifg_d & ie_q);
            for (int a = 0; a < 4; a++) begin
                dma_tx_req[a] <= ifg_d[`IVL_F_TX0 - 2 * a];
                dma_rx_req[a] <= ifg_d[`IVL_F_TX0 - 1 - 2 * a];
            end
            ctrl <= ctrl_q;
            ctrl.start_generate_bit <= 1'b0;
            if (wr_done && paddr == `IVL_OFF_CTRL) begin
                ctrl <= pwdata[7:0];
            end
            if (ev.arb_lost) begin
                ctrl.master_select <= 1'b0;
            end
        end
    end

endmodule : ivl_top

// [verification/ivl_top_monitor.sv]
// Purpose: Concurrent checks on the ports of the vector logic.
// Assumes: One pclk domain, presetn asynchronous and active low.
// Notes: Bound to ivl_top after the module.
module ivl_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire ivl_pkg::ivl_ev_s ev,
    input wire logic global_irq_enable,
    input wire logic irq,
    input wire logic [3:0] dma_tx_req,
    input wire logic [3:0] dma_rx_req,
    input wire logic clk_request,
    input wire ivl_pkg::ivl_ctrl_s ctrl,
    input wire logic tx_load
);
    // ****************************************************************
    // Port relations, all sampled on the rising pclk edge.
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // The access phase lasts exactly two cycles.
    apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not in second access cycle");
    gie_gate_a: assert property (!global_irq_enable |=> !irq)
        else $error("irq raised without global enable");
    addr_tx_a: assert property (
        ev.addr_match && !ctrl.master_select && !ctrl.early_tx_select
        |=> dma_tx_req[$past(ev.match_idx)])
        else $error("matched address did not raise its tx request");
    rx_load_a: assert property (
        ev.rx_load && !ctrl.soft_reset_bit |=> dma_rx_req != 4'h0)
        else $error("receive load did not raise an rx request");
    srst_rx_a: assert property (
        ctrl.soft_reset_bit |=> dma_rx_req == 4'h0)
        else $error("rx request seen during soft reset");
    arb_clear_a: assert property (ev.arb_lost |=> !ctrl.master_select)
        else $error("master select kept after arbitration loss");
    txbuf_clear_a: assert property (
        tx_load && !$past(ev.addr_match) && !$past(ev.tx_accept)
        |-> dma_tx_req == 4'h0)
        else $error("tx request kept after buffer write");
    busy_clk_a: assert property (ev.busy |=> clk_request)
        else $error("clock not requested while busy");
endmodule : ivl_top_monitor

bind ivl_top ivl_top_monitor ivl_top_monitor_inst (.pclk, .presetn, .psel,
    .penable, .pready, .ev, .global_irq_enable, .irq, .dma_tx_req,
    .dma_rx_req, .clk_request, .ctrl, .tx_load);

// [verification/ivl_cpu_model.sv]
// Purpose: Behavioural core that owns the global interrupt enable.
// Assumes: Runs on pclk.
// Notes: The enable follows the allow request one edge later.
module ivl_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic allow,
    input wire logic irq,
    output logic global_irq_enable,
    output logic irq_taken
);
    // Interrupts stay off until the core asks for them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable <= 1'b0;
        end else begin
            global_irq_enable <= allow;
        end
    end
    // A request counts only while interrupts are on.
    assign irq_taken = irq & global_irq_enable;
endmodule : ivl_cpu_model

// [verification/tb_ivl_top.sv]
// Purpose: Self-checking bench for the interrupt vector logic.
// Assumes: APB master with one idle cycle between transfers.
// Notes: Transfers note expectations in a queue that a watcher checks.
`include "ivl_params.svh"
module tb_ivl_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, allow = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic scl_in = 1'b1, sda_in = 1'b1;
    logic [7:0] paddr = 8'h00, rx_data = 8'h00, byte_count = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'hA414;
    logic pready, pslverr, irq, irq_taken, global_irq_enable;
    logic clk_request, tx_load;
    logic [3:0] dma_tx_req, dma_rx_req;
    logic [7:0] tx_data;
    logic [33:0] note;
    logic [33:0] notes[$];
    ivl_pkg::ivl_ev_s ev = '0;
    ivl_pkg::ivl_ctrl_s ctrl;
    int miscompares = 0, tests_run = 0;

    ivl_top #(.TO1_CYC(20), .TO2_CYC(30), .TO3_CYC(40)) ivl_top_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .scl_in, .sda_in, .ev, .rx_data, .byte_count,
        .global_irq_enable, .irq, .dma_tx_req, .dma_rx_req, .clk_request,
        .ctrl, .tx_data, .tx_load);
    ivl_cpu_model ivl_cpu_model_inst (.pclk, .presetn, .allow, .irq,
        .global_irq_enable, .irq_taken);

    // Free-running 40 MHz clock.
    always #12.5 pclk = ~pclk;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // One APB transfer; holds the request until pready, then idles a cycle.
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic err);
        int n;
        notes.push_back({wr, err, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n == 50) begin
                miscompares++;
                wrap_up();
            end
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, exp, 1'b0);
    endtask : rd

    task automatic pulse(input ivl_pkg::ivl_ev_s e);
        ev <= e;
        @(posedge pclk);
        ev <= '0;
        @(posedge pclk);
    endtask : pulse

    // Holds both bus pins for half a 200 ns link period.
    task automatic pins(input logic c, input logic d);
        scl_in <= c;
        sda_in <= d;
        repeat (4) @(posedge pclk);
    endtask : pins

    // Each completed transfer is matched against the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
            if (!note[33]) begin
                chk("prdata", note[31:0], prdata);
            end
        end
    end

    // Watchdog on the whole run.
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        logic [14:0] m;
        logic [31:0] d, tx;
        int b;
        ivl_pkg::ivl_ev_s e;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`IVL_OFF_IFG, 32'h0800);
        rd(`IVL_OFF_IE, 32'h0);
        rd(`IVL_OFF_CTRL, 32'h1);
        xfer(1'b0, 8'h20, 32'h0, 1'b1);
        wr(`IVL_OFF_CTRL, 32'h0);
        allow <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            m = 15'(rnd());
            wr(`IVL_OFF_IE, {17'h0, m});
            wr(`IVL_OFF_IFG, 32'h7FFF);
            chk("irq", {31'h0, m != 15'h0}, {31'h0, irq});
            while (m != 15'h0) begin
                for (b = 0; !m[b]; b++);
                rd(`IVL_OFF_IV, 2 * (b + 1));
                m[b] = 1'b0;
                if (b == 0) m &= ~`IVL_TX_MASK;
            end
            rd(`IVL_OFF_IV, 32'h0);
            wr(`IVL_OFF_IV, 32'h0);
            rd(`IVL_OFF_IFG, 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            e = '0;
            e.addr_match = 1'b1;
            e.match_idx = 2'(i);
            pulse(e);
            d = rnd();
            rx_data <= d[7:0];
            e = '0;
            e.rx_load = 1'b1;
            pulse(e);
            tx = 32'h1 << (`IVL_F_TX0 - 2 * i);
            rd(`IVL_OFF_IFG, (32'h1 << `IVL_F_STT) | tx | (tx >> 1));
            rd(`IVL_OFF_RXBUF, {24'h0, d[7:0]});
            rd(`IVL_OFF_IFG, (32'h1 << `IVL_F_STT) | tx);
            wr(`IVL_OFF_TXBUF, d);
            chk("tx_data", {24'h0, d[7:0]}, {24'h0, tx_data});
            rd(`IVL_OFF_IFG, 32'h1 << `IVL_F_STT);
            wr(`IVL_OFF_IV, 32'h0);
        end
        wr(`IVL_OFF_CTRL, 32'h08);
        pins(1'b1, 1'b0);
        for (int y = 0; y < 2; y++) begin
            ev.addr_phase <= (y == 0);
            repeat (9) begin
                pins(1'b0, 1'b0);
                pins(1'b1, 1'b0);
            end
        end
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        rd(`IVL_OFF_IFG, 32'h4808);
        wr(`IVL_OFF_IV, 32'h0);
        wr(`IVL_OFF_CTRL, 32'h40);
        ev.busy <= 1'b1;
        scl_in <= 1'b0;
        repeat (40) @(posedge pclk);
        scl_in <= 1'b1;
        ev.busy <= 1'b0;
        rd(`IVL_OFF_IFG, 32'h1 << `IVL_F_CLTO);
        repeat (40) @(posedge pclk);
        rd(`IVL_OFF_IFG, 32'h1 << `IVL_F_CLTO);
        wr(`IVL_OFF_IE, 32'h7FFF);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        chk("irq_taken", 32'h1, {31'h0, irq_taken});
        allow <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        allow <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            wr(`IVL_OFF_IV, 32'h0);
            wr(`IVL_OFF_TBCNT, 32'h3);
            wr(`IVL_OFF_CTRL, a << 4);
            byte_count <= 8'h03;
            repeat (2) @(posedge pclk);
            byte_count <= 8'h00;
            rd(`IVL_OFF_IFG, (a == 1 || a == 2) ? 32'h1000 : 32'h0);
        end
        for (int s = 0; s < 2; s++) begin
            wr(`IVL_OFF_IV, 32'h0);
            wr(`IVL_OFF_CTRL, s << 1);
            e = '0;
            e.nack = 1'b1;
            pulse(e);
            rd(`IVL_OFF_IFG, s << 1);
        end
        e = '0;
        e.arb_lost = 1'b1;
        pulse(e);
        rd(`IVL_OFF_CTRL, 32'h0);
        rd(`IVL_OFF_IFG, 32'h3);
        wr(`IVL_OFF_IV, 32'h0);
        wr(`IVL_OFF_TBCNT, 32'h2);
        wr(`IVL_OFF_CTRL, 32'h26);
        rd(`IVL_OFF_IFG, 32'h0800);
        e = '0;
        e.tx_accept = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(`IVL_OFF_TXBUF, rnd());
            pulse(e);
            rd(`IVL_OFF_IFG, k == 0 ? 32'h0800 : 32'h0);
        end
        wr(`IVL_OFF_CTRL, 32'h1);
        e = '0;
        e.rx_load = 1'b1;
        pulse(e);
        rd(`IVL_OFF_IFG, 32'h0);
        rd(`IVL_OFF_IE, 32'h700F);
        wrap_up();
    end
endmodule : tb_ivl_top
